// *** pkg/readout_pkg.sv ***
// Constants, encodings and layouts shared by the RAM readout block
package readout_pkg;
  localparam int unsigned WORD_W = 64;
  localparam int unsigned RAW_W = 192;
  localparam int unsigned LOC_W = 32;
  localparam int unsigned IDX_W = 17;
  localparam int unsigned PA_W = 40;
  localparam logic [1:0] EL_TOP = 2'h3;
  localparam logic [1:0] REG_COUNT = 2'h3;
  // Selector codes held in the top byte of the location word
  localparam int unsigned SEL_LO = 24;
  localparam logic [7:0] SEL_IDATA = 8'h01, SEL_BRANCH = 8'h02;
  localparam logic [7:0] SEL_HIST = 8'h03, SEL_ITLB = 8'h04;
  localparam logic [7:0] SEL_BIMODAL = 8'h05, SEL_MACRO = 8'h06;
  localparam logic [7:0] SEL_DTAG = 8'h08, SEL_DDATA = 8'h09;
  localparam logic [7:0] SEL_DTLB = 8'h0A, SEL_L2TAG = 8'h10;
  localparam logic [7:0] SEL_L2DATA = 8'h11, SEL_L2VICT = 8'h12;
  localparam logic [7:0] SEL_L2TLB = 8'h18;
  // Field positions and widths of the L1 location words
  localparam int unsigned L1_WAY_LO = 18, L1_WAY_W = 2;
  localparam int unsigned IDATA_LO = 3, IDATA_W = 11;
  localparam int unsigned BRANCH_LO = 4, BRANCH_W = 12;
  localparam int unsigned HIST_LO = 5, HIST_W = 11;
  localparam int unsigned BIMODAL_LO = 4, BIMODAL_W = 11;
  localparam int unsigned MACRO_LO = 0, MACRO_W = 11;
  localparam int unsigned DL1_LO = 6, DL1_W = 8;
  localparam int unsigned SUB_LO = 16, SUB_W = 2;
  localparam int unsigned ENTRY_LO = 0, ENTRY_W = 8, DTLB_ENTRY_W = 6;
  localparam logic [7:0] L1_TLB_LAST = 8'h2F;
  localparam logic [1:0] DTAG_COPY_NONE = 2'h3;
  localparam logic [2:0] L2_TLB_WAY_LAST = 3'h4;
  localparam logic [4:0] L2_DATA_1MB_FLIP = 5'h08;
  // Widths of the live low fields of returned words
  localparam int unsigned IDATA_HI_W = 9, BRANCH_HI_W = 28;
  localparam int unsigned BIMODAL_DATA_W = 16, MACRO_HI_W = 28;
  localparam int unsigned DDATA_SIDE_W = 32;
  localparam int unsigned ITLB2_W = 1, DTLB2_W = 6;
  localparam logic [2:0] PG_4KB = 3'h0, PG_16KB = 3'h1;
  localparam logic [2:0] PG_64KB = 3'h2, PG_2MB = 3'h4;

  typedef enum logic [3:0] {K_NONE, K_IDATA, K_BRANCH, K_HIST, K_ITLB,
    K_BIMODAL, K_MACRO, K_DTAG, K_DDATA, K_DTLB, K_L2TAG, K_L2DATA,
    K_L2TLB, K_L2VICT
  } ram_kind_type;
  typedef enum logic [2:0] {MT_DEV_NGNRNE = 3'h0, MT_DEV_NGNRE, MT_DEV_NGRE,
    MT_DEV_GRE, MT_NON_CACHEABLE, MT_WRITEBACK_NO_ALLOCATE, MT_WB_TRANSIENT,
    MT_WB_RW_ALLOCATE} mem_type_type;
  typedef enum logic [2:0] {RG_SEC_EL1 = 3'h0, RG_SEC_EL2 = 3'h1,
    RG_NS_EL1 = 3'h2, RG_NS_EL2 = 3'h3, RG_EL3 = 3'h5} regime_type;
  typedef enum logic [1:0] {COH_INVALID, COH_SHARED, COH_EXCLUSIVE,
    COH_MODIFIED} coherence_type;
  typedef enum logic [1:0] {TS_INVALID = 2'h0, TS_SHARED = 2'h1,
    TS_DIRTY = 2'h3} tag_state_type;
  typedef struct packed {logic data_side; logic [1:0] num;} rd_sel_type;

  typedef struct packed {
    logic [2:0] va_hi; logic [1:0] hw_attribute_bits; logic attr_58;
    mem_type_type mem_type; logic [2:0] page_size; logic [3:0] attr_51_48;
    logic outer_shared; logic inner_shared; logic [5:0] attr_45_40;
    logic [15:0] asid; logic [15:0] vmid;
    regime_type translation_regime_code; logic [3:0] attr_4_1; logic valid;
  } itlb0_type;
  typedef struct packed {
    logic attr_63; logic non_secure; logic [27:0] pa; logic [33:0] va;
  } itlb1_type;
  typedef struct packed {
    logic va_12; logic [1:0] ordering_region_id; logic ordering_match;
    logic outer_shared; logic inner_shared; logic [1:0] s1_regime;
    logic [1:0] s2_regime; mem_type_type mem_type; logic attr_50;
    logic dirty_bit_modifier_s2; logic dirty_bit_modifier_s1;
    logic coalesced; logic [3:0] permission; logic device_access_trap;
    logic not_global; logic smash; logic [2:0] page_size; logic non_secure;
    regime_type translation_regime_code; logic [15:0] asid;
    logic [15:0] vmid; logic valid;
  } dtlb0_type;
  typedef struct packed {logic [27:0] pa; logic [35:0] va;} dtlb1_type;
  typedef struct packed {
    logic memory_tagging; logic stage2_override_flag;
    logic [3:0] hw_attribute_bits;
  } dtlb2_type;
  typedef struct packed {
    logic zero; logic [6:0] ecc; logic [28:0] ns_pa; logic origin;
    logic prefetch; logic transient; logic [3:0] tag_poison;
    logic [15:0] tag_data; tag_state_type tag_state;
    coherence_type coherence;
  } dtag0_type;
  // Location word layouts of the L2 RAMs
  typedef struct packed {
    logic [7:0] sel; logic [2:0] rsv_a; logic [2:0] way; logic [1:0] rsv_b;
    logic [2:0] i15_13; logic [2:0] x12_10; logic [1:0] i9_8;
    logic [1:0] x7_6; logic [1:0] pa5_4; logic [3:0] rsv_c;
  } l2tag512_type;
  typedef struct packed {
    logic [7:0] sel; logic [2:0] rsv_a; logic [2:0] way; logic rsv_b;
    logic [4:0] i16_12; logic [2:0] x11_9; logic i8; logic [1:0] x7_6;
    logic [1:0] pa5_4; logic [3:0] rsv_c;
  } l2tag1m_type;
  typedef struct packed {
    logic [7:0] sel; logic [2:0] rsv_a; logic [2:0] way;
    logic [9:0] rsv_b; logic [7:0] entry;
  } l2tlb_type;
  typedef struct packed {
    logic [7:0] sel; logic [6:0] rsv_a; logic i16; logic [7:0] i15_8;
    logic [1:0] x7_6; logic [5:0] rsv_b;
  } l2vict_type;

  // Extract a field of a location word, right aligned
  function automatic logic [IDX_W-1:0] field(input logic [LOC_W-1:0] w,
      input int unsigned lo, input int unsigned width);
    logic [LOC_W-1:0] m;
    m = (w >> lo) & ~({LOC_W{1'b1}} << width);
    return m[IDX_W-1:0];
  endfunction

  // Keep the low n bits of a returned word, clear the rest
  function automatic logic [WORD_W-1:0] keep_low(input logic [WORD_W-1:0] w,
      input int unsigned n);
    return w & ~({WORD_W{1'b1}} << n);
  endfunction
endpackage

// *** pkg/loc_if.sv ***
// Location word and its decoded fields between readout and decoder
`timescale 1ns/1ps
interface loc_if;
  import readout_pkg::*;
  logic [LOC_W-1:0] word;
  logic l2_1mb;
  ram_kind_type kind;
  logic [2:0] way;
  logic [IDX_W-1:0] index;
  logic [1:0] sub;
  logic [7:0] entry;
  modport decoder (input word, l2_1mb,
    output kind, way, index, sub, entry);
  modport user (output word, l2_1mb,
    input kind, way, index, sub, entry);
endinterface

// *** core/location_decode.sv ***
// Decoder of the location word into RAM kind, way, index and entry
`timescale 1ns/1ps
module location_decode (
  loc_if.decoder loc
);
  import readout_pkg::*;

  logic [7:0] sel;
  l2tag512_type t512;
  l2tag1m_type t1m;
  l2tlb_type tlb2;
  l2vict_type vict;
  logic [IDX_W-1:0] l1_way;
  logic [IDX_W-1:0] l1_sub;

  // All layouts overlay the word; the selector picks the one in use
  always_comb begin
    t512 = l2tag512_type'(loc.word);
    t1m = l2tag1m_type'(loc.word);
    tlb2 = l2tlb_type'(loc.word);
    vict = l2vict_type'(loc.word);
    sel = t512.sel;
    l1_way = field(loc.word, L1_WAY_LO, L1_WAY_W);
    l1_sub = field(loc.word, SUB_LO, SUB_W);
    loc.kind = K_NONE;
    loc.way = 3'(l1_way);
    loc.index = '0;
    loc.sub = '0;
    loc.entry = '0;
    case (sel)
      SEL_IDATA: loc.kind = K_IDATA;
      SEL_BRANCH: loc.kind = K_BRANCH;
      SEL_HIST: loc.kind = K_HIST;
      SEL_BIMODAL: loc.kind = K_BIMODAL;
      SEL_MACRO: loc.kind = K_MACRO;
      SEL_DDATA: loc.kind = K_DDATA;
      // Copy code 3 names no tag pipe, so nothing is fetched
      SEL_DTAG: loc.kind = (2'(l1_sub) == DTAG_COPY_NONE) ? K_NONE : K_DTAG;
      // Entries past the last slot are not fetched
      SEL_ITLB: begin
        loc.entry = 8'(field(loc.word, ENTRY_LO, ENTRY_W));
        loc.kind = (loc.entry <= L1_TLB_LAST) ? K_ITLB : K_NONE;
      end
      SEL_DTLB: begin
        loc.entry = 8'(field(loc.word, ENTRY_LO, DTLB_ENTRY_W));
        loc.kind = (loc.entry <= L1_TLB_LAST) ? K_DTLB : K_NONE;
      end
      // Eight ways; the requester scrambles index with way
      SEL_L2TAG, SEL_L2DATA: begin
        loc.kind = (sel == SEL_L2TAG) ? K_L2TAG : K_L2DATA;
        if (loc.l2_1mb) begin
          loc.way = t1m.way;
          loc.index[16:12] = t1m.i16_12;
          if (sel == SEL_L2DATA) begin
            loc.index[16:12] = t1m.i16_12 ^ L2_DATA_1MB_FLIP;
          end
          loc.index[11:9] = t1m.x11_9 ^ t1m.way;
          loc.index[8] = t1m.i8;
          loc.index[7:6] = t1m.x7_6 ^ loc.index[11:10] ^ t1m.way[2:1];
          loc.sub = (sel == SEL_L2DATA) ? t1m.pa5_4 : '0;
        end else begin
          loc.way = t512.way;
          loc.index[15:13] = t512.i15_13;
          loc.index[12:10] = t512.x12_10 ^ t512.way;
          loc.index[9:8] = t512.i9_8;
          loc.index[7:6] = t512.x7_6 ^ loc.index[11:10] ^ t512.way[1:0];
          loc.sub = (sel == SEL_L2DATA) ? t512.pa5_4 : '0;
        end
      end
      SEL_L2TLB: begin
        loc.way = tlb2.way;
        loc.entry = tlb2.entry;
        loc.kind = (tlb2.way <= L2_TLB_WAY_LAST) ? K_L2TLB : K_NONE;
      end
      SEL_L2VICT: begin
        loc.kind = K_L2VICT;
        loc.way = '0;
        loc.index[16] = vict.i16;
        loc.index[15:8] = vict.i15_8;
        loc.index[7:6] = vict.x7_6 ^ loc.index[11:10];
      end
      default: loc.kind = K_NONE;
    endcase
    // L1 set index fields sit at a per-RAM position
    case (loc.kind)
      K_IDATA: loc.index = field(loc.word, IDATA_LO, IDATA_W);
      K_BRANCH: loc.index = field(loc.word, BRANCH_LO, BRANCH_W);
      K_HIST: loc.index = field(loc.word, HIST_LO, HIST_W);
      K_BIMODAL: loc.index = field(loc.word, BIMODAL_LO, BIMODAL_W);
      K_MACRO: loc.index = field(loc.word, MACRO_LO, MACRO_W);
      K_DTAG, K_DDATA: begin
        loc.index = field(loc.word, DL1_LO, DL1_W);
        loc.sub = 2'(l1_sub);
      end
      default: loc.index = loc.index;
    endcase
  end
endmodule

// *** core/internal_ram_readout.sv ***
// Debug readout of internal cache, predictor and TLB RAM entries
// Notes on behaviour
// - Instruction data entry bits 72:64 go to word 1 low bits, rest zero.
// - Branch target entry: 63:0 word 0, 91:64 word 1 low, word 2 zero.
// - Global history 128 bits split across words 0 and 1, word 2 zero.
// - Bimodal 16-bit entry in word 0 low bits, all else zero.
// - Instruction TLB word 0 bits 57:55 carry the memory type code.
// - Instruction TLB word 0 holds ASID, VMID, regime, page size, valid.
// - Instruction TLB word 1 holds NS, PA, VA; word 2 one bit.
// - Macro-op entry low 64 bits in word 0, upper bits in word 1.
// - Data tag word 0 holds ECC, PA, flags, tag poison and data.
// - Data tag low bits hold coherence state and memory tag state.
// - Data RAM words in words 0 and 1, ECC and poison word 2.
// - Data TLB word 0 top holds ordering, share, regime, type, perms.
// - Data TLB word 0 low holds page size, NS, regime, ASID, VMID.
// - Data TLB word 1 holds PA and VA; word 2 six attribute bits.
// - L2 has eight ways; selector picks tag, data, TLB or victim.
// - Set index is the PA hashed with its upper bits.
// - Readout never modifies any cache or TLB content.
// - Only the top privilege level may read; others get undefined.
`timescale 1ns/1ps
module internal_ram_readout (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] exec_level,
  input wire logic loc_write,
  input wire logic [readout_pkg::LOC_W-1:0] loc_word,
  input wire logic l2_is_1mb,
  output logic loc_accept,
  output logic loc_undef,
  input wire logic rd_en,
  input wire readout_pkg::rd_sel_type rd_sel,
  output logic rd_valid,
  output logic rd_undef,
  output logic [readout_pkg::WORD_W-1:0] rd_data,
  output logic ram_req,
  output logic [7:0] ram_selector,
  output logic [2:0] ram_way,
  output logic [readout_pkg::IDX_W-1:0] ram_index,
  output logic [1:0] ram_sub,
  output logic [7:0] ram_entry,
  input wire logic ram_ack,
  input wire logic [readout_pkg::RAW_W-1:0] ram_data,
  input wire logic [readout_pkg::PA_W-1:0] phys_addr,
  output logic [readout_pkg::IDX_W-1:0] set_index,
  output logic busy
);
  import readout_pkg::*;

  typedef enum logic {ST_IDLE, ST_WAIT} state_type;
  typedef logic [2:0][WORD_W-1:0] bank_type;

  state_type state_q, state_d;
  logic req_q, req_d;
  ram_kind_type kind_q, kind_d;
  logic [7:0] sel_q, sel_d;
  logic [2:0] way_q, way_d;
  logic [IDX_W-1:0] index_q, index_d;
  logic [1:0] sub_q, sub_d;
  logic [7:0] entry_q, entry_d;
  bank_type instr_q, instr_d;
  bank_type data_q, data_d;
  bank_type fmt;
  logic el_ok;
  logic rd_valid_q, rd_valid_d;
  logic rd_undef_q, rd_undef_d;
  logic [WORD_W-1:0] rd_data_q, rd_data_d;
  logic [IDX_W-1:0] set_index_q, set_index_d;

  loc_if loc ();

  // Which bank a RAM kind lands in
  function automatic logic is_data_side(input ram_kind_type k);
    return k inside {K_DTAG, K_DDATA, K_DTLB, K_L2TAG, K_L2DATA, K_L2VICT};
  endfunction

  // Set index hash of a physical address
  function automatic logic [IDX_W-1:0] set_index_of(
      input logic [PA_W-1:0] pa, input logic mb1);
    logic [IDX_W-1:0] idx;
    idx = '0;
    if (mb1) begin
      idx[16:8] = pa[16:8] ^ pa[25:17];
    end else begin
      idx[15:8] = pa[15:8] ^ pa[23:16];
    end
    idx[7:6] = pa[7:6] ^ pa[11:10];
    return idx;
  endfunction

  // Shape a raw RAM entry into three readout words
  function automatic bank_type format_entry(input ram_kind_type k,
      input logic [RAW_W-1:0] raw);
    bank_type w;
    bank_type r;
    dtag0_type tag;
    dtlb0_type d0;
    r = raw;
    w = '0;
    tag = dtag0_type'(r[0]);
    d0 = dtlb0_type'(r[0]);
    case (k)
      K_IDATA: begin
        w[0] = r[0];
        w[1] = keep_low(r[1], IDATA_HI_W);
      end
      K_BRANCH: begin
        w[0] = r[0];
        w[1] = keep_low(r[1], BRANCH_HI_W);
      end
      K_HIST: begin
        w[0] = r[0];
        w[1] = r[1];
      end
      K_BIMODAL: w[0] = keep_low(r[0], BIMODAL_DATA_W);
      K_MACRO: begin
        w[0] = r[0];
        w[1] = keep_low(r[1], MACRO_HI_W);
      end
      // The TLB hands its fields over already in word order
      K_ITLB: begin
        w[0] = itlb0_type'(r[0]);
        w[1] = itlb1_type'(r[1]);
        w[2] = keep_low(r[2], ITLB2_W);
      end
      K_DTAG: begin
        tag.zero = 1'b0;
        w[0] = tag;
      end
      K_DDATA: begin
        w[0] = r[0];
        w[1] = r[1];
        w[2] = keep_low(r[2], DDATA_SIDE_W);
      end
      K_DTLB: begin
        d0.attr_50 = 1'b0;
        w[0] = d0;
        w[1] = dtlb1_type'(r[1]);
        w[2] = keep_low(r[2], DTLB2_W);
      end
      // L2 entries come back in their final layout
      default: w = r;
    endcase
    return w;
  endfunction

  assign loc.word = loc_word;
  assign loc.l2_1mb = l2_is_1mb;

  location_decode u_decode (
    .loc(loc)
  );

  assign el_ok = (exec_level == EL_TOP);
  // A new location is taken only between fetches
  assign loc_accept = (state_q == ST_IDLE);
  assign loc_undef = loc_write && !el_ok;
  assign busy = (state_q == ST_WAIT);
  assign ram_req = req_q;
  assign ram_selector = sel_q;
  assign ram_way = way_q;
  assign ram_index = index_q;
  assign ram_sub = sub_q;
  assign ram_entry = entry_q;
  assign rd_valid = rd_valid_q;
  assign rd_undef = rd_undef_q;
  assign rd_data = rd_data_q;
  assign set_index = set_index_q;

  // Fetch sequencer; the RAM port has no write path at all
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    kind_d = kind_q;
    sel_d = sel_q;
    way_d = way_q;
    index_d = index_q;
    sub_d = sub_q;
    entry_d = entry_q;
    instr_d = instr_q;
    data_d = data_q;
    fmt = format_entry(kind_q, ram_data);
    unique case (state_q)
      ST_IDLE: begin
        // Unknown selectors are dropped so held words stay intact
        if (loc_write && el_ok && loc.kind != K_NONE) begin
          state_d = ST_WAIT;
          req_d = 1'b1;
          kind_d = loc.kind;
          sel_d = loc_word[LOC_W-1:SEL_LO];
          way_d = loc.way;
          index_d = loc.index;
          sub_d = loc.sub;
          entry_d = loc.entry;
        end
      end
      ST_WAIT: begin
        if (ram_ack) begin
          state_d = ST_IDLE;
          req_d = 1'b0;
          // All three words of one side change together
          if (is_data_side(kind_q)) begin
            data_d = fmt;
          end else begin
            instr_d = fmt;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      req_q <= 1'b0;
      kind_q <= K_NONE;
      sel_q <= '0;
      way_q <= '0;
      index_q <= '0;
      sub_q <= '0;
      entry_q <= '0;
      instr_q <= '0;
      data_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      kind_q <= kind_d;
      sel_q <= sel_d;
      way_q <= way_d;
      index_q <= index_d;
      sub_q <= sub_d;
      entry_q <= entry_d;
      instr_q <= instr_d;
      data_q <= data_d;
    end
  end

  // Register reads; a read during a fetch sees the previous entry
  always_comb begin
    rd_valid_d = rd_en && el_ok;
    rd_undef_d = rd_en && !el_ok;
    rd_data_d = '0;
    if (rd_valid_d && rd_sel.num < REG_COUNT) begin
      rd_data_d = rd_sel.data_side ? data_q[rd_sel.num]
                                   : instr_q[rd_sel.num];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_undef_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_undef_q <= rd_undef_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Set index helper, one cycle behind the address
  always_comb begin
    set_index_d = set_index_of(phys_addr, l2_is_1mb);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      set_index_q <= '0;
    end else begin
      set_index_q <= set_index_d;
    end
  end

  undef_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd_en && exec_level != EL_TOP |=> rd_undef && !rd_valid && rd_data == '0
  ) else $error("read below top level not refused");

  undef_fetch_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    loc_write && exec_level != EL_TOP && !busy |-> loc_undef ##1 !ram_req
  ) else $error("location write below top level started a fetch");

  hold_words_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(busy && ram_ack) |=> $stable(instr_q) && $stable(data_q)
  ) else $error("readout words changed without a fetch");

  side_only_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && !is_data_side(kind_q) |=> $stable(data_q)
  ) else $error("instruction fetch disturbed data words");

  req_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ram_req && !ram_ack |=> ram_req && $stable(ram_index) && $stable(ram_way)
  ) else $error("RAM request dropped or moved before answer");

  l2_select_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    loc_write && el_ok && !busy && loc_word[LOC_W-1:SEL_LO] == SEL_L2DATA
    |=> ram_req && ram_selector == SEL_L2DATA && kind_q == K_L2DATA
  ) else $error("L2 data selector not fetched");

  idata_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_IDATA |=>
      instr_q[1] == WORD_W'($past(ram_data[WORD_W+IDATA_HI_W-1:WORD_W]))
      && instr_q[2] == '0
  ) else $error("instruction data word 1 misformatted");

  branch_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_BRANCH |=>
      instr_q[1][WORD_W-1:BRANCH_HI_W] == '0 && instr_q[2] == '0
      && instr_q[0] == $past(ram_data[WORD_W-1:0])
  ) else $error("branch target words misformatted");

  bimodal_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_BIMODAL |=>
      instr_q[0][WORD_W-1:BIMODAL_DATA_W] == '0 && instr_q[1] == '0
      && instr_q[2] == '0
  ) else $error("bimodal words not zero above entry");

  macro_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_MACRO |=>
      instr_q[1][WORD_W-1:MACRO_HI_W] == '0 && instr_q[2] == '0
  ) else $error("macro-op words misformatted");

  itlb_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_ITLB |=>
      instr_q[2][WORD_W-1:ITLB2_W] == '0
  ) else $error("instruction TLB word 2 reserved bits set");

  dtag_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_DTAG |=>
      data_q[0][WORD_W-1] == 1'b0 && data_q[1] == '0 && data_q[2] == '0
  ) else $error("data tag words misformatted");

  ddata_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_DDATA |=>
      data_q[2][WORD_W-1:DDATA_SIDE_W] == '0
      && data_q[0] == $past(ram_data[WORD_W-1:0])
  ) else $error("data RAM words misformatted");

  dtlb_fmt_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && ram_ack && kind_q == K_DTLB |=>
      data_q[2][WORD_W-1:DTLB2_W] == '0
  ) else $error("data TLB word 2 reserved bits set");
endmodule

// *** test/test_internal_ram_readout.sv ***
// Testbench of the internal RAM readout block
`timescale 1ns/1ps
module test_internal_ram_readout;
  import readout_pkg::*;
  localparam logic [63:0] R0 = 64'hF0E1D2C3B4A59687;
  localparam logic [63:0] R1 = 64'h0123456789ABCDEF;
  localparam logic [63:0] R2 = 64'hFEDCBA9876543210;
  logic clock = 0, rst_n = 0, loc_write = 0, l2_is_1mb = 0;
  logic rd_en = 0, ram_ack = 0, loc_accept, loc_undef, rd_valid;
  logic rd_undef, ram_req, busy;
  logic [1:0] exec_level = 2'h3, ram_sub;
  logic [LOC_W-1:0] loc_word = 32'h0;
  rd_sel_type rd_sel = '0;
  logic [RAW_W-1:0] ram_data = {R2, R1, R0};
  logic [PA_W-1:0] phys_addr = 40'h123456789A;
  logic [WORD_W-1:0] rd_data;
  logic [7:0] ram_selector, ram_entry, got_entry;
  logic [2:0] ram_way, got_way;
  logic [1:0] got_sub;
  logic [IDX_W-1:0] ram_index, set_index, got_index;
  int n_errors = 0, n_tests = 0;

  internal_ram_readout i_dut (.clock(clock), .rst_n(rst_n),
    .exec_level(exec_level), .loc_write(loc_write), .loc_word(loc_word),
    .l2_is_1mb(l2_is_1mb), .loc_accept(loc_accept), .loc_undef(loc_undef),
    .rd_en(rd_en), .rd_sel(rd_sel), .rd_valid(rd_valid),
    .rd_undef(rd_undef), .rd_data(rd_data), .ram_req(ram_req),
    .ram_selector(ram_selector), .ram_way(ram_way), .ram_index(ram_index),
    .ram_sub(ram_sub), .ram_entry(ram_entry), .ram_ack(ram_ack),
    .ram_data(ram_data), .phys_addr(phys_addr), .set_index(set_index),
    .busy(busy));

  // 10 MHz core clock
  always #50 clock = ~clock;

  task automatic chk(input string what, input logic [63:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // Program a location word and answer the RAM request once
  task automatic fetch(input logic [31:0] w);
    int n;
    n = 0;
    loc_word = w;
    loc_write = 1;
    tick;
    loc_write = 0;
    while (ram_req !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        test_done;
      end
      tick;
    end
    got_way = ram_way;
    got_entry = ram_entry;
    got_index = ram_index;
    got_sub = ram_sub;
    chk("selector", 64'(w[31:24]), 64'(ram_selector));
    chk("busy", 64'h1, 64'(busy));
    chk("loc_accept", 64'h0, 64'(loc_accept));
    ram_ack = 1;
    tick;
    ram_ack = 0;
    chk("ram_req", 64'h0, 64'(ram_req));
    chk("loc_accept", 64'h1, 64'(loc_accept));
  endtask

  // One register read; the extra edge keeps rd_en pulses apart
  task automatic rd(input logic side, input logic [1:0] num,
      input logic [63:0] exp);
    rd_sel = '{side, num};
    rd_en = 1;
    tick;
    rd_en = 0;
    chk("rd_valid", 64'h1, 64'(rd_valid));
    chk("rd_data", exp, rd_data);
    tick;
  endtask

  task automatic run(input logic [7:0] sel, input logic side,
      input logic [63:0] e0, e1, e2);
    fetch({sel, 24'h0});
    rd(side, 2'h0, e0);
    rd(side, 2'h1, e1);
    rd(side, 2'h2, e2);
  endtask

  // Fetch an L2 location, compare the unscrambled address and word 2
  task automatic l2(input logic [31:0] w, input logic [IDX_W-1:0] idx,
      input logic [2:0] way, input logic [1:0] sub);
    fetch(w);
    chk("index", 64'(idx), 64'(got_index));
    chk("way", 64'(way), 64'(got_way));
    chk("sub", 64'(sub), 64'(got_sub));
    rd(1'b1, 2'h2, R2);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #1;
    rst_n = 1;
    rd(1'b1, 2'h2, 64'h0);
    fetch(32'h01000000);
    rd(1'b0, 2'h1, {55'h0, R1[8:0]});
    run(8'h02, 1'b0, R0, {36'h0, R1[27:0]}, 64'h0);
    run(8'h03, 1'b0, R0, R1, 64'h0);
    run(8'h05, 1'b0, {48'h0, R0[15:0]}, 64'h0, 64'h0);
    run(8'h06, 1'b0, R0, {36'h0, R1[27:0]}, 64'h0);
    run(8'h04, 1'b0, R0, R1, {63'h0, R2[0]});
    run(8'h08, 1'b1, {1'b0, R0[62:0]}, 64'h0, 64'h0);
    run(8'h09, 1'b1, R0, R1, {32'h0, R2[31:0]});
    run(8'h0A, 1'b1, {R0[63:51], 1'b0, R0[49:0]}, R1,
      {58'h0, R2[5:0]});
    rd(1'b0, 2'h2, {63'h0, R2[0]});
    fetch({8'h18, 3'h0, 3'h4, 10'h0, 8'hFF});
    chk("way", 64'h4, 64'(got_way));
    chk("entry", 64'hFF, 64'(got_entry));
    // 512KB: way 5, index fields 15:13=6, 12:10=3, 9:8=2, 7:6=1
    l2({8'h10, 3'h0, 3'h5, 2'h0, 3'h6, 3'h3 ^ 3'h5, 2'h2,
      2'h1 ^ 2'h3 ^ 2'h1, 6'h0}, {1'h0, 3'h6, 3'h3, 2'h2, 2'h1, 6'h0},
      3'h5, 2'h0);
    l2({8'h11, 3'h0, 3'h5, 2'h0, 3'h6, 3'h3 ^ 3'h5, 2'h2,
      2'h1 ^ 2'h3 ^ 2'h1, 2'h2, 4'h0}, {1'h0, 3'h6, 3'h3, 2'h2, 2'h1, 6'h0},
      3'h5, 2'h2);
    // Victim: index 11:10 is 1 inside 8'hA7, index 7:6 is 2
    l2({8'h12, 7'h0, 1'h1, 8'hA7, 2'h1 ^ 2'h2, 6'h0},
      {1'h1, 8'hA7, 2'h2, 6'h0}, 3'h0, 2'h0);
    // 1MB: way 6, index fields 16:12=13, 11:9=5, 8=1, 7:6=2
    l2_is_1mb = 1;
    l2({8'h10, 3'h0, 3'h6, 1'h0, 5'h13, 3'h5 ^ 3'h6, 1'h1,
      2'h2 ^ 2'h2 ^ 2'h3, 6'h0}, {5'h13, 3'h5, 1'h1, 2'h2, 6'h0},
      3'h6, 2'h0);
    l2({8'h11, 3'h0, 3'h6, 1'h0, 5'h13 ^ 5'h08, 3'h5 ^ 3'h6, 1'h1,
      2'h2 ^ 2'h2 ^ 2'h3, 2'h1, 4'h0}, {5'h13, 3'h5, 1'h1, 2'h2, 6'h0},
      3'h6, 2'h1);
    l2_is_1mb = 0;
    // A way past the last L2 TLB way starts no fetch
    loc_word = {8'h18, 3'h0, 3'h5, 18'h0};
    loc_write = 1;
    tick;
    loc_write = 0;
    chk("ram_req", 64'h0, 64'(ram_req));
    tick;
    // Below the top level nothing may be fetched or read
    exec_level = 2'h1;
    loc_word = {8'h05, 24'h0};
    loc_write = 1;
    #1;
    chk("loc_undef", 64'h1, 64'(loc_undef));
    tick;
    loc_write = 0;
    rd_en = 1;
    chk("ram_req", 64'h0, 64'(ram_req));
    tick;
    rd_en = 0;
    chk("rd_undef", 64'h1, 64'(rd_undef));
    chk("rd_data", 64'h0, rd_data);
    exec_level = 2'h3;
    tick;
    rd(1'b0, 2'h0, R0);
    chk("set_index", 64'({phys_addr[15:8] ^ phys_addr[23:16],
      phys_addr[7:6] ^ phys_addr[11:10]}), 64'(set_index[15:6]));
    l2_is_1mb = 1;
    tick;
    chk("set_index", 64'({phys_addr[16:8] ^ phys_addr[25:17],
      phys_addr[7:6] ^ phys_addr[11:10]}), 64'(set_index[16:6]));
    test_done;
  end
endmodule
